//--- core/dma_layer_params.svh
/*
  Register offsets, field positions and reset values of the channel DMA
  layer register bank. Bit positions are given in LSB-0 order; the bus
  convention numbers bit 0 as the MSB, so bus bit n sits at 31-n.
  Assumes inclusion by bare name from the design files only.
*/
`ifndef DMA_LAYER_PARAMS_SVH
`define DMA_LAYER_PARAMS_SVH

// Register-port addresses
`define ADR_CFG      10'h180
`define ADR_ESR      10'h181
`define ADR_IER      10'h182
`define ADR_RXSET    10'h190
`define ADR_RXCLR    10'h191
`define ADR_RXTBL    10'h1c0
`define ADR_RXBSZ    10'h1e0

// Configuration fields
`define CFG_SR       31
`define CFG_PRIO_HI  23
`define CFG_PRIO_LO  22
`define CFG_GA       21
`define CFG_OA       20
`define CFG_LE       19
`define CFG_LAT_HI   18
`define CFG_LAT_LO   15
`define CFG_BURST    14
`define CFG_PLOCK    7
`define CFG_EVERY_PACKET_IRQ    2
`define CFG_LEA      1
`define CFG_SD       0
`define CFG_WMASK    32'h00ff_c087

// Error status fields
`define ESR_EVB      31
`define ESR_CID_HI   30
`define ESR_CID_LO   25
`define ESR_TYP_HI   20
`define ESR_TYP_LO   16
`define ESR_IRQ_HI   4
`define ESR_IRQ_LO   0

// Channel-active bit, buffer size width
`define RX_CH0       31
`define BSZ_HI       7

// Reset values and soft reset length
`define CFG_RST      32'h0000_0000
`define IER_RST      5'h00
`define SRST_CYCLES  1

`endif

//--- core/dma_layer_pkg.sv
/*
  Types shared by the DMA layer register bank and its bench.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package dma_layer_pkg;

  // One register-port request, valid for the cycle it is seen
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [9:0]  addr;
    logic [31:0] wdata;
  } dcr_req_t;

  // Error report; kind one-hot: [4] desc, [3] partial, [2] timeout,
  // [1] periph slave, [0] local bus
  typedef struct packed {
    logic       valid;
    logic       is_rx;
    logic [4:0] chan;
    logic [4:0] kind;
  } err_event_t;

  // Attributes driven with every local-bus request
  typedef struct packed {
    logic [1:0] prio;
    logic       guarded;
    logic       ordered;
    logic       lock_error;
    logic       burst_allow;
    logic [3:0] latency;
  } lb_attr_t;

endpackage : dma_layer_pkg

//--- core/rx_stage_fifo.sv
/*
  Receive-path FIFO with registered read data and registered ready.
  Assumes one clock, synchronous active-high reset, and that the
  caller gives the next-cycle enable for the filling side.
*/
`timescale 1ns/1ps
module rx_stage_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  input  wire logic             clock,
  input  wire logic             rst,
  input  wire logic             en_nxt,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);

  // Pointers wrap naturally only for power-of-two depths
  generate
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
      $error("rx_stage_fifo: DEPTH must be a power of two >= 2");
    end
  endgenerate

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_r;
  logic [AW-1:0]    rd_ptr_r;
  logic [AW:0]      count_r;
  logic [AW:0]      count_nxt;
  logic             push;
  logic             pop;

  // Pop into the output register whenever it is free or being taken
  assign push = in_valid & in_ready;
  assign pop  = (count_r != '0) & (~out_valid | out_ready);
  assign count_nxt = count_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

  // Storage has no reset; only pointers matter
  always_ff @(posedge clock) begin
    if (push) begin
      mem[wr_ptr_r] <= in_data;
    end
  end

  // Pointers, fill level and registered ready
  always_ff @(posedge clock) begin
    if (rst) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
      in_ready <= 1'b0;
    end else begin
      wr_ptr_r <= wr_ptr_r + AW'(push);
      rd_ptr_r <= rd_ptr_r + AW'(pop);
      count_r  <= count_nxt;
      in_ready <= en_nxt & (count_nxt != (AW+1)'(DEPTH));
    end
  end

  // Output register; holds until the drain side takes it
  always_ff @(posedge clock) begin
    if (rst) begin
      out_valid <= 1'b0;
      out_data  <= '0;
    end else begin
      out_valid <= pop | (out_valid & ~out_ready);
      if (pop) begin
        out_data <= mem[rd_ptr_r];
      end
    end
  end

endmodule : rx_stage_fifo

//--- core/dma_layer_config_status_regs.sv
/*
  Configuration, error status, interrupt enable and receive channel
  registers of the channel DMA layer, with the attribute, burst, lock,
  packet-interrupt and skip controls they steer, and the receive FIFO.
  Assumes a device-control register port whose requests last one cycle
  and are answered by an ack one cycle later; unmapped addresses get no
  ack, so the port master times out as usual for that bus.
*/
`timescale 1ns/1ps
`include "dma_layer_params.svh"
module dma_layer_config_status_regs
  import dma_layer_pkg::*;
#(
  parameter int FIFO_WIDTH = 32,
  parameter int FIFO_DEPTH = 16
) (
  input  wire logic                  clock,
  input  wire logic                  rst,
  input  wire dcr_req_t              dcr_req,
  output logic                       dcr_ack,
  output logic [31:0]                dcr_rdata,
  input  wire err_event_t            err_evt,
  input  wire logic                  req_is_status_wr,
  output lb_attr_t                   lb_attr,
  input  wire logic                  burst_busy,
  output logic                       burst_stop,
  input  wire logic                  periph_xfer,
  output logic                       periph_lock,
  input  wire logic                  eop_evt,
  input  wire logic                  eop_desc_irq,
  output logic                       eop_irq,
  input  wire logic                  early_end,
  output logic                       skip_next,
  output logic                       rx_active,
  output logic [7:0]                 rx_buf_size,
  output logic [31:0]                rx_table_base,
  output logic                       error_irq,
  input  wire logic [FIFO_WIDTH-1:0] rx_in_data,
  input  wire logic                  rx_in_valid,
  output logic                       rx_in_ready,
  output logic [FIFO_WIDTH-1:0]      rx_out_data,
  output logic                       rx_out_valid,
  input  wire logic                  rx_out_ready
);

  // Data must fit a bus word; the FIFO checks its own depth
  generate
    if (FIFO_WIDTH < 1 || FIFO_WIDTH > 32) begin : g_bad_width
      $error("dma_layer: FIFO_WIDTH must be 1..32");
    end
  endgenerate

  // The soft pulse is a single flop; a longer reset would need a counter
  generate
    if (`SRST_CYCLES != 1) begin : g_bad_srst
      $error("dma_layer: soft reset must last exactly one clock");
    end
  endgenerate

  // Address match, shared by read mux and write strobes
  // Full ten-bit compare, so the block has no aliases
  function automatic logic hit(input logic [9:0] a, input logic [9:0] r);
    hit = (a == r);
  endfunction : hit

  logic [31:0] cfg_r;
  logic        soft_rst_r;
  logic        evb_r;
  logic [5:0]  cid_r;
  logic [4:0]  typ_r;
  logic [4:0]  flag_r;
  logic [4:0]  ier_r;
  logic [3:0]  burst_cnt_r;

  // Address decode
  wire sel_cfg = hit(dcr_req.addr, `ADR_CFG);
  wire sel_esr = hit(dcr_req.addr, `ADR_ESR);
  wire sel_ier = hit(dcr_req.addr, `ADR_IER);
  wire sel_set = hit(dcr_req.addr, `ADR_RXSET);
  wire sel_clr = hit(dcr_req.addr, `ADR_RXCLR);
  wire sel_tbl = hit(dcr_req.addr, `ADR_RXTBL);
  wire sel_bsz = hit(dcr_req.addr, `ADR_RXBSZ);
  wire sel_any = sel_cfg | sel_esr | sel_ier | sel_set
               | sel_clr | sel_tbl | sel_bsz;
  // Unmapped addresses get neither an ack nor a side effect
  wire take    = (dcr_req.rd | dcr_req.wr) & sel_any;

  // Write strobes; a read riding on the same request returns
  // the value from before the write
  wire wr_cfg = dcr_req.wr & sel_cfg;
  wire wr_esr = dcr_req.wr & sel_esr;
  wire wr_ier = dcr_req.wr & sel_ier;
  wire wr_set = dcr_req.wr & sel_set;
  wire wr_clr = dcr_req.wr & sel_clr;
  wire wr_tbl = dcr_req.wr & sel_tbl;
  wire wr_bsz = dcr_req.wr & sel_bsz;

  // All of the layer but the port answer resets on the port reset or the one-cycle soft pulse
  wire srst = rst | soft_rst_r;

  // Soft reset pulse: set by a write of one, gone after one clock
  // Clears on its own pulse so it can never latch itself on
  always_ff @(posedge clock) begin
    if (rst | soft_rst_r) begin
      soft_rst_r <= 1'b0;
    end else begin
      soft_rst_r <= wr_cfg & dcr_req.wdata[`CFG_SR];
    end
  end

  // Configuration; reserved bits never store
  // The soft reset bit is not stored; it reads back from the pulse flop
  always_ff @(posedge clock) begin
    if (srst) begin
      cfg_r <= `CFG_RST;
    end else if (wr_cfg) begin
      cfg_r <= dcr_req.wdata & `CFG_WMASK;
    end
  end

  // Configuration fields
  // Latency and burst also feed the burst counter below
  wire [1:0] cfg_prio  = cfg_r[`CFG_PRIO_HI:`CFG_PRIO_LO];
  wire [3:0] cfg_lat   = cfg_r[`CFG_LAT_HI:`CFG_LAT_LO];
  wire       cfg_burst = cfg_r[`CFG_BURST];
  wire       cfg_lea   = cfg_r[`CFG_LEA];

  // Write-one-to-clear mask for the error status
  // Only the valid flag and the sticky flags respond to it
  wire [31:0] esr_clr = wr_esr ? dcr_req.wdata : 32'h0000_0000;
  wire        ev      = err_evt.valid;
  wire        lb_err  = err_evt.kind[0];

  // Locked mode refuses new captures while the valid flag holds;
  // a clear in the same cycle frees the fields for this event
  wire evb_free = ~evb_r | esr_clr[`ESR_EVB];
  wire capture  = ev & (evb_free | ~cfg_lea);

  // Valid flag: event beats a simultaneous software clear
  wire evb_nxt = ev | (evb_r & ~esr_clr[`ESR_EVB]);

  // Sticky flags: set wins over clear
  wire [4:0] flag_set = ev ? err_evt.kind : 5'h00;
  wire [4:0] flag_nxt = flag_set
                      | (flag_r & ~esr_clr[`ESR_IRQ_HI:`ESR_IRQ_LO]);

  // Channel id only meaningful for peripheral-bus errors
  // A local-bus error has no channel, so the field is zeroed
  wire [5:0] cid_nxt = lb_err ? 6'h00
                     : {err_evt.is_rx, err_evt.chan};

  // Error capture registers
  // Type and channel survive a clear, as the last record for software
  always_ff @(posedge clock) begin
    if (srst) begin
      evb_r  <= 1'b0;
      cid_r  <= 6'h00;
      typ_r  <= 5'h00;
      flag_r <= 5'h00;
    end else begin
      evb_r  <= evb_nxt;
      flag_r <= flag_nxt;
      if (capture) begin
        cid_r <= cid_nxt;
        typ_r <= err_evt.kind;
      end
    end
  end

  // Interrupt enables; written over the port so they can be armed
  // All enables start cleared, so error interrupts start masked
  always_ff @(posedge clock) begin
    if (srst) begin
      ier_r <= `IER_RST;
    end else if (wr_ier) begin
      ier_r <= dcr_req.wdata[`ESR_IRQ_HI:`ESR_IRQ_LO];
    end
  end

  // Error interrupt follows next flag state, so it drops with the clear
  // A newly written enable takes effect one clock after the write
  always_ff @(posedge clock) begin
    if (srst) begin
      error_irq <= 1'b0;
    end else begin
      error_irq <= |(flag_nxt & ier_r);
    end
  end

  // Receive channel active: set register enables, clear register disables
  // Writing one to the clear register is ignored; only a zero disables
  wire rx_active_nxt = wr_set & dcr_req.wdata[`RX_CH0] ? 1'b1
                     : wr_clr & ~dcr_req.wdata[`RX_CH0] ? 1'b0
                     : rx_active;

  always_ff @(posedge clock) begin
    if (srst) begin
      rx_active <= 1'b0;
    end else begin
      rx_active <= rx_active_nxt;
    end
  end

  // Table base kept as written; alignment is the writer's duty
  always_ff @(posedge clock) begin
    if (srst) begin
      rx_table_base <= 32'h0000_0000;
    end else if (wr_tbl) begin
      rx_table_base <= dcr_req.wdata;
    end
  end

  // Buffer size: eight bits, rest reserved
  // Upper bits are dropped on write and read back as zero
  always_ff @(posedge clock) begin
    if (srst) begin
      rx_buf_size <= 8'h00;
    end else if (wr_bsz) begin
      rx_buf_size <= dcr_req.wdata[`BSZ_HI:0];
    end
  end

  // Local-bus attributes; status writes always ordered
  // Registered, so the engine sees a stable set for a whole request
  wire ordered_nxt = cfg_r[`CFG_OA] | req_is_status_wr;

  always_ff @(posedge clock) begin
    if (srst) begin
      lb_attr <= '0;
    end else begin
      lb_attr.prio        <= cfg_prio;
      lb_attr.guarded     <= cfg_r[`CFG_GA];
      lb_attr.ordered     <= ordered_nxt;
      lb_attr.lock_error  <= cfg_r[`CFG_LE];
      lb_attr.burst_allow <= cfg_burst;
      lb_attr.latency     <= cfg_lat;
    end
  end

  // Burst length counter; stops at the latency limit, or at once
  // when bursting is forbidden
  // The count saturates at the limit, so a long burst cannot wrap
  wire lat_hit  = burst_cnt_r >= cfg_lat;
  wire stop_nxt = burst_busy & (~cfg_burst | lat_hit);

  always_ff @(posedge clock) begin
    if (srst) begin
      burst_cnt_r <= 4'h0;
      burst_stop  <= 1'b0;
    end else begin
      burst_stop <= stop_nxt;
      if (!burst_busy) begin
        burst_cnt_r <= 4'h0;
      end else if (!lat_hit) begin
        burst_cnt_r <= burst_cnt_r + 4'h1;
      end
    end
  end

  // Peripheral lock, packet interrupt and skip strobes
  // Registered, so each follows its gated cause one clock behind, for as long as the cause lasts
  wire eop_irq_nxt = eop_evt & (cfg_r[`CFG_EVERY_PACKET_IRQ] | eop_desc_irq);
  wire skip_nxt    = early_end & cfg_r[`CFG_SD];

  always_ff @(posedge clock) begin
    if (srst) begin
      periph_lock <= 1'b0;
      eop_irq     <= 1'b0;
      skip_next   <= 1'b0;
    end else begin
      periph_lock <= periph_xfer & cfg_r[`CFG_PLOCK];
      eop_irq     <= eop_irq_nxt;
      skip_next   <= skip_nxt;
    end
  end

  // Read views; reserved bits read zero
  // Vector bit 31-n carries bus bit n of the register
  wire [31:0] cfg_view = cfg_r | ({31'h0, soft_rst_r} << `CFG_SR);
  wire [31:0] esr_view = {evb_r,   // Valid flag
                          cid_r,   // Direction and channel
                          4'h0,
                          typ_r,   // Type of the recorded error
                          11'h000,
                          flag_r}; // Sticky flags
  wire [31:0] ier_view = {27'h000_0000, ier_r};
  wire [31:0] act_view = {rx_active, 31'h0000_0000};
  wire [31:0] bsz_view = {24'h00_0000, rx_buf_size};

  // Read mux
  wire [31:0] rd_mux = sel_cfg ? cfg_view
                     : sel_esr ? esr_view
                     : sel_ier ? ier_view
                     : (sel_set | sel_clr) ? act_view
                     : sel_tbl ? rx_table_base
                     : sel_bsz ? bsz_view
                     : 32'h0000_0000;

  // Port answer; the port itself survives a soft reset so the
  // write that caused it is still acknowledged
  always_ff @(posedge clock) begin
    if (rst) begin
      dcr_ack   <= 1'b0;
      dcr_rdata <= 32'h0000_0000;
    end else begin
      dcr_ack   <= take;
      dcr_rdata <= (take & dcr_req.rd) ? rd_mux : 32'h0000_0000;
    end
  end

  // Receive path buffer; filling side only open while channel active
  // Ready is registered, so it is fed next cycle's channel state, and a
  // soft-reset write closes it one edge ahead of the reset itself
  rx_stage_fifo #(
    .WIDTH (FIFO_WIDTH),
    .DEPTH (FIFO_DEPTH)
  ) u_rx_fifo (
    .clock     (clock),
    .rst       (srst),
    .en_nxt    (rx_active_nxt & ~(wr_cfg & dcr_req.wdata[`CFG_SR])),
    .in_data   (rx_in_data),
    .in_valid  (rx_in_valid),
    .in_ready  (rx_in_ready),
    .out_data  (rx_out_data),
    .out_valid (rx_out_valid),
    .out_ready (rx_out_ready)
  );

endmodule : dma_layer_config_status_regs

//--- testbench/dma_layer_chk.sv
/*
  Port-level checker for the DMA layer register bank.
  Assumes it is bound to the top module and sees only its ports.
*/
`timescale 1ns/1ps
module dma_layer_chk
  import dma_layer_pkg::*;
(
  input wire logic       clock,
  input wire logic       rst,
  input wire dcr_req_t   dcr_req,
  input wire logic       dcr_ack,
  input wire logic [31:0] dcr_rdata,
  input wire err_event_t err_evt,
  input wire logic       req_is_status_wr,
  input wire lb_attr_t   lb_attr,
  input wire logic       burst_busy,
  input wire logic       burst_stop,
  input wire logic       periph_xfer,
  input wire logic       periph_lock,
  input wire logic       eop_evt,
  input wire logic       eop_desc_irq,
  input wire logic       eop_irq,
  input wire logic       early_end,
  input wire logic       skip_next,
  input wire logic       rx_active,
  input wire logic       rx_in_ready,
  input wire logic       error_irq
);
  logic hit;
  logic cfg_wr;

  // Mapped request and config write decode
  assign hit = (dcr_req.rd | dcr_req.wr) &
               (dcr_req.addr inside {10'h180, 10'h181, 10'h182, 10'h190, 10'h191, 10'h1c0, 10'h1e0});
  assign cfg_wr = dcr_req.wr & (dcr_req.addr == 10'h180);

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  a_ack_mapped: assert property (hit |=> dcr_ack) else $error("mapped request not acked");
  a_ack_cause: assert property (dcr_ack |-> $past(hit)) else $error("ack without request");
  a_rdata_idle: assert property (!dcr_ack |-> dcr_rdata == 32'h0000_0000) else $error("rdata without ack");
  a_attr_cfg: assert property (cfg_wr && !dcr_req.wdata[31] |-> ##2
    (lb_attr.prio == $past(dcr_req.wdata[23:22], 2) && lb_attr.guarded == $past(dcr_req.wdata[21], 2) &&
     lb_attr.lock_error == $past(dcr_req.wdata[19], 2) && lb_attr.burst_allow == $past(dcr_req.wdata[14], 2) &&
     lb_attr.latency == $past(dcr_req.wdata[18:15], 2))) else $error("attributes differ from config");
  a_ordered_status: assert property (req_is_status_wr |=> lb_attr.ordered) else $error("status write unordered");
  a_lock_idle: assert property (!periph_xfer |=> !periph_lock) else $error("lock outside transfer");
  a_eop_desc: assert property (eop_evt && eop_desc_irq |=> eop_irq) else $error("flagged packet end lost");
  a_eop_quiet: assert property (!eop_evt |=> !eop_irq) else $error("packet irq without end");
  a_skip_quiet: assert property (!early_end |=> !skip_next) else $error("skip without early end");
  a_stop_busy: assert property (burst_stop |-> $past(burst_busy)) else $error("stop without burst");
  a_irq_rise: assert property ($rose(error_irq) |-> $past(err_evt.valid) || $past(dcr_req.wr, 2))
    else $error("error irq without cause");
  a_srst_all: assert property (cfg_wr && dcr_req.wdata[31] |-> ##2
    (lb_attr == '0 && !rx_active && !rx_in_ready && !error_irq)) else $error("soft reset incomplete");

  c_burst_stop: cover property (burst_stop);
  c_error_irq: cover property (error_irq);
  c_skip: cover property (skip_next);
endmodule : dma_layer_chk

bind dma_layer_config_status_regs dma_layer_chk u_dma_layer_chk (.clock, .rst, .dcr_req, .dcr_ack, .dcr_rdata,
  .err_evt, .req_is_status_wr, .lb_attr, .burst_busy, .burst_stop, .periph_xfer, .periph_lock, .eop_evt,
  .eop_desc_irq, .eop_irq, .early_end, .skip_next, .rx_active, .rx_in_ready, .error_irq);

//--- testbench/rx_word_source.sv
/*
  Communication-controller model pushing receive words.
  Assumes go pulses for one cycle while idle; words count from a base.
*/
`timescale 1ns/1ps
module rx_word_source (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        go,
  input  wire logic [7:0]  n,
  output logic [31:0]      data,
  output logic             valid,
  input  wire logic        ready,
  output logic [7:0]       sent
);
  // Word held until taken; while valid is low the data lines toggle
  always_ff @(posedge clock) begin
    if (rst) begin
      valid <= 1'b0;
      sent  <= 8'h00;
      data  <= 32'h0000_0000;
    end else if (go) begin
      valid <= 1'b1;
      sent  <= 8'h00;
      data  <= 32'ha500_0000;
    end else if (valid && ready) begin
      sent  <= sent + 8'h01;
      valid <= (sent + 8'h01) < n;
      data  <= 32'ha500_0000 + 32'(sent + 8'h01);
    end else if (!valid) begin
      data  <= ~data;
    end
  end
endmodule : rx_word_source

//--- testbench/tb.sv
/*
  Self-checking bench for the DMA layer register bank.
  Assumes the register port acks one cycle after a mapped request.
*/
`timescale 1ns/1ps
module tb;
  import dma_layer_pkg::*;
  logic clock = 1'b0;
  logic rst, st_wr, busy, pxfer, eop, eop_d, early, oready, go, ack, stop, plock, pirq, skip, ract, eirq;
  logic in_ready, in_valid, out_valid;
  logic [31:0] rdata, tbase, in_data, out_data;
  logic [7:0] bsize, sent, n_words;
  logic [4:0] kd, ch, fl;
  dcr_req_t req;
  err_event_t evt;
  lb_attr_t attr;
  int miscompares = 0;
  int cmp_count = 0;
  int got_cnt = 0;
  int n;

  always #4 clock = ~clock;

  dma_layer_config_status_regs u_dma_layer_config_status_regs (.clock(clock), .rst(rst), .dcr_req(req),
    .dcr_ack(ack), .dcr_rdata(rdata), .err_evt(evt), .req_is_status_wr(st_wr), .lb_attr(attr),
    .burst_busy(busy), .burst_stop(stop), .periph_xfer(pxfer), .periph_lock(plock), .eop_evt(eop),
    .eop_desc_irq(eop_d), .eop_irq(pirq), .early_end(early), .skip_next(skip), .rx_active(ract),
    .rx_buf_size(bsize), .rx_table_base(tbase), .error_irq(eirq), .rx_in_data(in_data),
    .rx_in_valid(in_valid), .rx_in_ready(in_ready), .rx_out_data(out_data), .rx_out_valid(out_valid),
    .rx_out_ready(oready));
  rx_word_source u_rx_word_source (.clock(clock), .rst(rst), .go(go), .n(n_words), .data(in_data),
    .valid(in_valid), .ready(in_ready), .sent(sent));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // One register access: request held for the taking edge only
  task automatic dcr(input logic r, input logic w, input logic [9:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic k);
    @(posedge clock) req <= '{rd: r, wr: w, addr: a, wdata: d};
    @(posedge clock) req <= '0;
    #1;
    k = ack;
    q = rdata;
  endtask : dcr

  task automatic wr(input logic [9:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic k;
    dcr(1'b0, 1'b1, a, d, q, k);
    chk(32'(k), 32'h0000_0001);
  endtask : wr

  task automatic rd(input logic [9:0] a, input logic [31:0] e);
    logic [31:0] q;
    logic k;
    dcr(1'b1, 1'b0, a, 32'h0000_0000, q, k);
    chk(32'(k), 32'h0000_0001);
    chk(q, e);
  endtask : rd

  task automatic err(input logic [4:0] kind, input logic [4:0] c);
    @(posedge clock) evt <= '{valid: 1'b1, is_rx: c[0], chan: c, kind: kind};
    @(posedge clock) evt <= '0;
  endtask : err

  // Cycles from burst start until the stop request shows
  task automatic burst_len(output int m);
    @(posedge clock) busy <= 1'b1;
    m = 0;
    while (stop !== 1'b1 && m < 20) begin
      @(posedge clock);
      #1;
      m++;
    end
    @(posedge clock) busy <= 1'b0;
  endtask : burst_len

  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : end_of_test

  // Drain monitor: words must leave in order
  always @(posedge clock) begin
    if (oready && out_valid === 1'b1) begin
      chk(out_data, 32'ha500_0000 + 32'(got_cnt));
      got_cnt++;
    end
  end

  // Cuts a hang short
  initial begin
    repeat (5000) @(posedge clock);
    miscompares++;
    end_of_test;
  end

  initial begin
    {rst, st_wr, busy, pxfer, eop, eop_d, early, oready, go} = 9'h1_00;
    req = '0;
    evt = '0;
    n_words = 8'h00;
    fl = 5'h00;
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    rd(10'h180, 32'h0000_0000);
    wr(10'h180, 32'h7fff_ffff);
    rd(10'h180, 32'h00ff_c087);
    chk(32'(attr), 32'h0000_03ff);
    @(posedge clock) pxfer <= 1'b1;
    @(posedge clock) pxfer <= 1'b0;
    #1 chk(32'(plock), 32'h0000_0001);
    wr(10'h180, 32'h8040_0000);
    rd(10'h180, 32'h0000_0000);
    @(posedge clock) st_wr <= 1'b1;
    @(posedge clock) st_wr <= 1'b0;
    #1 chk(32'(attr.ordered), 32'h0000_0001);
    wr(10'h180, 32'h0001_4000);
    burst_len(n);
    chk(32'(n), 32'h0000_0003);
    wr(10'h180, 32'h0001_0000);
    burst_len(n);
    chk(32'(n), 32'h0000_0001);
    for (int i = 0; i < 4; i++) begin
      wr(10'h180, {29'h0, i[1], 1'b0, i[1]});
      @(posedge clock) {eop, eop_d, early} <= {1'b1, i[0], 1'b1};
      @(posedge clock) {eop, early} <= 2'b00;
      #1 chk(32'(pirq), 32'(i[1] | i[0]));
      chk(32'(skip), 32'(i[1]));
    end
    wr(10'h182, 32'h0000_001f);
    for (int k = 0; k < 5; k++) begin
      kd = 5'h01 << k;
      ch = 5'(k + 1);
      fl = fl | kd;
      err(kd, ch);
      rd(10'h181, {1'b1, (kd[0] ? 6'h00 : {ch[0], ch}), 4'h0, kd, 11'h000, fl});
      chk(32'(eirq), 32'h0000_0001);
    end
    wr(10'h181, 32'h8000_001f);
    rd(10'h181, {1'b0, 1'b1, 5'h05, 4'h0, 5'h10, 11'h000, 5'h00});
    wr(10'h182, 32'h0000_0000);
    err(5'h10, 5'h01);
    rd(10'h182, 32'h0000_0000);
    chk(32'(eirq), 32'h0000_0000);
    wr(10'h182, 32'h0000_0010);
    rd(10'h182, 32'h0000_0010);
    chk(32'(eirq), 32'h0000_0001);
    wr(10'h181, 32'h8000_001f);
    wr(10'h180, 32'h0000_0002);
    err(5'h04, 5'h03);
    err(5'h02, 5'h05);
    rd(10'h181, {1'b1, 1'b1, 5'h03, 4'h0, 5'h04, 11'h000, 5'h06});
    wr(10'h1e0, 32'hffff_ffff);
    rd(10'h1e0, 32'h0000_00ff);
    chk(32'(bsize), 32'h0000_00ff);
    wr(10'h1c0, 32'h1234_5670);
    rd(10'h1c0, 32'h1234_5670);
    chk(tbase, 32'h1234_5670);
    begin : unmapped
      logic [31:0] q;
      logic k;
      dcr(1'b1, 1'b0, 10'h183, 32'h0000_0000, q, k);
      chk(32'(k), 32'h0000_0000);
    end
    wr(10'h190, 32'h8000_0000);
    wr(10'h191, 32'h8000_0000);
    rd(10'h190, 32'h8000_0000);
    chk(32'(ract), 32'h0000_0001);
    @(posedge clock) {go, n_words} <= {1'b1, 8'h14};
    @(posedge clock) go <= 1'b0;
    repeat (40) @(posedge clock);
    #1 chk(32'(sent), 32'h0000_0011);
    chk(32'(in_ready), 32'h0000_0000);
    repeat (80) @(posedge clock) oready <= ~oready;
    chk(32'(got_cnt), 32'h0000_0014);
    wr(10'h191, 32'h0000_0000);
    rd(10'h190, 32'h0000_0000);
    chk(32'(ract), 32'h0000_0000);
    end_of_test;
  end
endmodule : tb
